// File: rtl/udi_top.sv
// Purpose: Divisor latches, irq enable, interrupt identification and FIFO control
// Assumes: Register port with read data one cycle after the strobe
// Notes: Serial shifters and FIFO storage sit outside and join through the ports
`timescale 1ns/1ps
`include "udi_defs.svh"
module udi_top (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic [`UDI_AW-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic [7:0] rx_byte_i,
	input wire logic [7:0] line_status_i,
	input wire logic line_err_i,
	input wire logic rx_ready_i,
	input wire logic rx_timeout_i,
	input wire logic tx_holding_empty_flag_i,
	output logic [7:0] tx_byte_o,
	output logic tx_wr_o,
	output logic rx_rd_o,
	output logic [7:0] line_ctrl_o,
	output logic divisor_access_select_o,
	output logic fifo_enable_bit_o,
	output logic receive_fifo_clear_o,
	output logic transmit_fifo_clear_o,
	output logic [1:0] rx_trigger_o,
	output logic baud_tick_o,
	output logic irq_o
);
	udi_baud_if bif ();

	// ------------------------------
	// Decode
	// ------------------------------
	function automatic logic hit(input logic [`UDI_AW-1:0] a, input logic [`UDI_AW-1:0] ofs);
		hit = (a == ofs);
	endfunction

	function automatic logic [3:0] id_code(input udi_pkg::udi_src_t s);
		case (s)
			udi_pkg::UDI_SRC_LS: id_code = `UDI_ID_LS;
			udi_pkg::UDI_SRC_TMO: id_code = `UDI_ID_TMO;
			udi_pkg::UDI_SRC_RDA: id_code = `UDI_ID_RDA;
			udi_pkg::UDI_SRC_TXE: id_code = `UDI_ID_TXE;
			default: id_code = `UDI_ID_NONE;
		endcase
	endfunction

	logic div_sel;
	logic wr_data;
	logic wr_divlo;
	logic wr_divhi;
	logic wr_ier;
	logic wr_fcr;
	logic rd_ident;
	logic rd_lstat;
	logic rd_rx;

	assign div_sel = line_ctrl_o[`UDI_LCR_DIVSEL];
	assign wr_divhi = wr_i && hit(addr_i, `UDI_OFS_DATA) && div_sel;
	assign wr_divlo = wr_i && hit(addr_i, `UDI_OFS_DIVLO) && div_sel;
	assign wr_data = wr_i && hit(addr_i, `UDI_OFS_DATA) && !div_sel;
	assign wr_ier = wr_i && hit(addr_i, `UDI_OFS_DIVLO) && !div_sel;
	assign wr_fcr = wr_i && hit(addr_i, `UDI_OFS_IDENT);
	assign rd_ident = rd_i && hit(addr_i, `UDI_OFS_IDENT);
	assign rd_lstat = rd_i && hit(addr_i, `UDI_OFS_LSTAT);
	assign rd_rx = rd_i && hit(addr_i, `UDI_OFS_DATA) && !div_sel;

	// ------------------------------
	// Register file
	// ------------------------------
	logic [7:0] dll_ff, nxt_dll;
	logic [7:0] dlm_ff, nxt_dlm;
	logic [`UDI_IER_W-1:0] ier_ff, nxt_ier;
	logic [7:0] lcr_ff, nxt_lcr;
	logic fen_ff, nxt_fen;
	logic [1:0] trg_ff, nxt_trg;
	logic rxclr_ff, nxt_rxclr;
	logic txclr_ff, nxt_txclr;
	logic [7:0] txb_ff, nxt_txb;
	logic txwr_ff, nxt_txwr;
	logic rxrd_ff, nxt_rxrd;
	logic load_ff, nxt_load;

	always_comb begin
		nxt_dll = dll_ff;
		nxt_dlm = dlm_ff;
		nxt_ier = ier_ff;
		nxt_lcr = lcr_ff;
		nxt_fen = fen_ff;
		nxt_trg = trg_ff;
		nxt_rxclr = 1'b0;
		nxt_txclr = 1'b0;
		nxt_txb = txb_ff;
		nxt_txwr = wr_data;
		nxt_rxrd = rd_rx;
		nxt_load = wr_divlo || wr_divhi;
		if (wr_divlo) begin
			nxt_dll = wdata_i;
		end
		if (wr_divhi) begin
			nxt_dlm = wdata_i;
		end
		if (wr_ier) begin
			nxt_ier = wdata_i[`UDI_IER_W-1:0];
		end
		if (wr_data) begin
			nxt_txb = wdata_i;
		end
		if (wr_i && hit(addr_i, `UDI_OFS_LCR)) begin
			nxt_lcr = wdata_i;
		end
		if (wr_fcr) begin
			nxt_fen = wdata_i[`UDI_FCR_EN];
			nxt_trg = {wdata_i[`UDI_FCR_TRG_HI], wdata_i[`UDI_FCR_TRG_LO]};
			nxt_rxclr = wdata_i[`UDI_FCR_RXCLR];
			nxt_txclr = wdata_i[`UDI_FCR_TXCLR];
			// Dropping the enable empties both FIFOs
			if (fen_ff && !wdata_i[`UDI_FCR_EN]) begin
				nxt_rxclr = 1'b1;
				nxt_txclr = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			dll_ff <= `UDI_BYTE_RST;
			dlm_ff <= `UDI_BYTE_RST;
			ier_ff <= `UDI_IER_RST;
			lcr_ff <= `UDI_BYTE_RST;
			fen_ff <= 1'b0;
			trg_ff <= `UDI_TRG_RST;
			rxclr_ff <= 1'b0;
			txclr_ff <= 1'b0;
			txb_ff <= `UDI_BYTE_RST;
			txwr_ff <= 1'b0;
			rxrd_ff <= 1'b0;
			load_ff <= 1'b0;
		end else if (ce_i) begin
			dll_ff <= nxt_dll;
			dlm_ff <= nxt_dlm;
			ier_ff <= nxt_ier;
			lcr_ff <= nxt_lcr;
			fen_ff <= nxt_fen;
			trg_ff <= nxt_trg;
			rxclr_ff <= nxt_rxclr;
			txclr_ff <= nxt_txclr;
			txb_ff <= nxt_txb;
			txwr_ff <= nxt_txwr;
			rxrd_ff <= nxt_rxrd;
			load_ff <= nxt_load;
		end
	end

	assign bif.divisor = {dlm_ff, dll_ff};
	assign bif.load = load_ff && ce_i;

	udi_baud u_baud (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.ce_i(ce_i),
		.bif(bif)
	);

	// ------------------------------
	// Interrupt sources
	// ------------------------------
	logic ls_ff, nxt_ls;
	logic txe_ff, nxt_txe;
	logic txe_seen_ff, nxt_txe_seen;
	logic [3:0] ident_ff, nxt_ident;
	logic irq_ff, nxt_irq;
	logic hold_ff, nxt_hold;
	logic txe_set;
	udi_pkg::udi_src_t top_src;

	assign txe_set = tx_holding_empty_flag_i && !txe_seen_ff;

	always_comb begin
		nxt_txe_seen = tx_holding_empty_flag_i;
		// Set wins over clear in both sticky flags
		nxt_ls = line_err_i || (ls_ff && !rd_lstat);
		nxt_txe = txe_set || (txe_ff && !wr_data &&
			!(rd_ident && ident_ff == `UDI_ID_TXE));
		top_src = udi_pkg::UDI_SRC_NONE;
		if (ls_ff && ier_ff[`UDI_IER_LS]) begin
			top_src = udi_pkg::UDI_SRC_LS;
		end else if (rx_ready_i && ier_ff[`UDI_IER_RDA]) begin
			top_src = udi_pkg::UDI_SRC_RDA;
		end else if (rx_timeout_i && fen_ff && ier_ff[`UDI_IER_RDA]) begin
			top_src = udi_pkg::UDI_SRC_TMO;
		end else if (txe_ff && ier_ff[`UDI_IER_TXE]) begin
			top_src = udi_pkg::UDI_SRC_TXE;
		end
		nxt_hold = rd_ident;
		nxt_ident = ident_ff;
		nxt_irq = irq_ff;
		// Freeze the indication through the strobe and its data cycle
		if (!rd_ident && !hold_ff) begin
			nxt_ident = id_code(top_src);
			nxt_irq = (top_src != udi_pkg::UDI_SRC_NONE);
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			ls_ff <= 1'b0;
			txe_ff <= 1'b0;
			txe_seen_ff <= 1'b0;
			ident_ff <= `UDI_ID_NONE;
			irq_ff <= 1'b0;
			hold_ff <= 1'b0;
		end else if (ce_i) begin
			ls_ff <= nxt_ls;
			txe_ff <= nxt_txe;
			txe_seen_ff <= nxt_txe_seen;
			ident_ff <= nxt_ident;
			irq_ff <= nxt_irq;
			hold_ff <= nxt_hold;
		end
	end

	// ------------------------------
	// Read data
	// ------------------------------
	logic [7:0] rdata_ff, nxt_rdata;

	always_comb begin
		nxt_rdata = `UDI_BYTE_RST;
		if (rd_i) begin
			case (addr_i)
				`UDI_OFS_DATA: nxt_rdata = div_sel ? dlm_ff : rx_byte_i;
				`UDI_OFS_DIVLO: nxt_rdata = div_sel ? dll_ff : {5'h00, ier_ff};
				`UDI_OFS_IDENT: nxt_rdata = {{2{fen_ff}}, `UDI_ZERO2, ident_ff};
				`UDI_OFS_LCR: nxt_rdata = lcr_ff;
				`UDI_OFS_LSTAT: nxt_rdata = line_status_i;
				default: nxt_rdata = `UDI_BYTE_RST;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			rdata_ff <= `UDI_BYTE_RST;
		end else if (ce_i) begin
			rdata_ff <= nxt_rdata;
		end
	end

	// ------------------------------
	// Outputs
	// ------------------------------
	assign rdata_o = rdata_ff;
	assign tx_byte_o = txb_ff;
	assign tx_wr_o = txwr_ff;
	assign rx_rd_o = rxrd_ff;
	assign line_ctrl_o = lcr_ff;
	assign divisor_access_select_o = lcr_ff[`UDI_LCR_DIVSEL];
	assign fifo_enable_bit_o = fen_ff;
	assign receive_fifo_clear_o = rxclr_ff;
	assign transmit_fifo_clear_o = txclr_ff;
	assign rx_trigger_o = trg_ff;
	assign baud_tick_o = bif.tick;
	assign irq_o = irq_ff;

	// ------------------------------
	// Checks
	// ------------------------------
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (reset_i);

	sequence fcr_rxclr_s;
		ce_i && wr_fcr && wdata_i[`UDI_FCR_RXCLR];
	endsequence
	sequence clr_pulse_s;
		receive_fifo_clear_o ##1 !receive_fifo_clear_o;
	endsequence

	divlo_write_a: assert property (ce_i && wr_divlo |=> dll_ff == $past(wdata_i))
		else $error("low divisor latch not loaded");
	ier_blocked_a: assert property (ce_i && wr_i && div_sel &&
		hit(addr_i, `UDI_OFS_DIVLO) |=> $stable(ier_ff))
		else $error("irq enable changed while divisor access set");
	ident_hold_a: assert property (ce_i && rd_ident ##1 ce_i |=> $stable(ident_ff))
		else $error("indication changed during identification access");
	ident_read_a: assert property (ce_i && rd_ident |=>
		rdata_o[3:0] == $past(ident_ff))
		else $error("identification read data wrong");
	none_bit_a: assert property (irq_o == !ident_ff[0])
		else $error("bit 0 disagrees with interrupt output");
	ls_first_a: assert property (ce_i && !rd_ident && !hold_ff && ls_ff &&
		ier_ff[`UDI_IER_LS] |=> ident_ff == `UDI_ID_LS)
		else $error("line status not given top rank");
	txe_clear_a: assert property (ce_i && wr_data && !txe_set |=> !txe_ff)
		else $error("transmitter empty not cleared by holding write");
	fifo_bits_a: assert property (ce_i && rd_ident |=>
		rdata_o[7:6] == {2{$past(fen_ff)}} && rdata_o[5:4] == `UDI_ZERO2)
		else $error("FIFO enabled bits wrong");
	rx_clear_a: assert property (fcr_rxclr_s ##1 (ce_i && !wr_fcr) |->
		clr_pulse_s)
		else $error("receive clear did not clear itself");
	disabled_a: assert property (ce_i && !rd_ident && !hold_ff &&
		ier_ff == `UDI_IER_RST |=> !irq_o)
		else $error("disabled interrupt reached controller");
endmodule

// File: rtl/udi_defs.svh
// Purpose: Constants for the divisor latch and interrupt identification block
// Assumes: Byte-wide registers at their printed offsets, one 125 MHz clock
// Notes: Timing and field positions used by the top and baud counter design files
//
// Notes on behaviour
// - With divisor access set, offset 1B1 reaches divisor low latch, else irq enable.
// - With divisor access set, writes at offsets 0 and 1 load divisor latches.
// - With divisor access set, data and irq enable registers cannot be reached.
// - Divisor is held as low and high byte forming one 16-bit value.
// - Writing either divisor latch reloads the baud counter one cycle after the latch updates.
// - Offset 1B2 reads interrupt identification and writes FIFO control.
// - Priority: line status first, received data second, receive timeout third, transmitter empty fourth.
// - Only the highest pending interrupt is presented as current indication.
// - During an identification access the indication holds; new events still latch.
// - Bit 0 reads 0 while any enabled interrupt pends, 1 otherwise.
// - Codes: 110 line status, 100 data, 010 transmitter empty, 001 none.
// - Transmitter empty clears on indicated identification read or holding write.
// - In FIFO mode a receive timeout sets bit 3 with bit 2.
// - Bits 6 and 7 read 1 while FIFOs enabled; bits 4, 5 reserved.
// - FIFO control write: enable, receive clear, transmit clear, trigger level.
// - FIFO clear bits empty the FIFO and clear themselves afterwards.
// - Each interrupt reaches the controller only when enabled; flags still update.
`ifndef UDI_DEFS_SVH
`define UDI_DEFS_SVH

`define UDI_AW 12
`define UDI_OFS_DATA 12'h1B0
`define UDI_OFS_DIVLO 12'h1B1
`define UDI_OFS_IDENT 12'h1B2
`define UDI_OFS_LCR 12'h1B3
`define UDI_OFS_LSTAT 12'h1B5

`define UDI_LCR_DIVSEL 7
`define UDI_IER_RDA 0
`define UDI_IER_TXE 1
`define UDI_IER_LS 2
`define UDI_IER_W 3

`define UDI_FCR_EN 0
`define UDI_FCR_RXCLR 1
`define UDI_FCR_TXCLR 2
`define UDI_FCR_TRG_LO 6
`define UDI_FCR_TRG_HI 7

`define UDI_ID_NONE 4'h1
`define UDI_ID_LS 4'h6
`define UDI_ID_RDA 4'h4
`define UDI_ID_TMO 4'hC
`define UDI_ID_TXE 4'h2

`define UDI_BYTE_RST 8'h00
`define UDI_DIV_RST 16'h0000
`define UDI_IER_RST 3'h0
`define UDI_TRG_RST 2'h0
`define UDI_ZERO2 2'h0

`endif

// File: rtl/udi_pkg.sv
// Purpose: Types shared by the divisor and identification block
// Assumes: Nothing beyond the constants header
// Notes: Interrupt sources in rising order of rank, except that timeout ranks below received data
package udi_pkg;
	typedef enum {
		UDI_SRC_NONE,
		UDI_SRC_TXE,
		UDI_SRC_RDA,
		UDI_SRC_TMO,
		UDI_SRC_LS
	} udi_src_t;
endpackage

// File: rtl/udi_baud_if.sv
// Purpose: Carries divisor, reload strobe and tick between register file and baud counter
// Assumes: Single clock domain
// Notes: load is a one-cycle pulse
`timescale 1ns/1ps
interface udi_baud_if;
	logic [15:0] divisor;
	logic load;
	logic tick;
	modport ctl (output divisor, output load, input tick);
	modport cnt (input divisor, input load, output tick);
endinterface

// File: rtl/udi_baud.sv
// Purpose: 16-bit baud counter giving one tick per divisor plus one cycles
// Assumes: Divisor already holds clock over sixteen times baud, minus one
// Notes: A load restarts the count at once
`timescale 1ns/1ps
`include "udi_defs.svh"
module udi_baud (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	udi_baud_if.cnt bif
);
	logic [15:0] cnt_ff;
	logic [15:0] nxt_cnt;
	logic tick_ff;
	logic nxt_tick;

	// ------------------------------
	// Counter
	// ------------------------------
	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_tick = 1'b0;
		if (bif.load) begin
			nxt_cnt = bif.divisor;
		end else if (cnt_ff == `UDI_DIV_RST) begin
			nxt_cnt = bif.divisor;
			nxt_tick = 1'b1;
		end else begin
			nxt_cnt = cnt_ff - 16'h0001;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			cnt_ff <= `UDI_DIV_RST;
			tick_ff <= 1'b0;
		end else if (ce_i) begin
			cnt_ff <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end

	assign bif.tick = tick_ff;

	// ------------------------------
	// Checks
	// ------------------------------
	reload_now_a: assert property (@(posedge mclk_i) disable iff (reset_i)
		ce_i && bif.load |=> cnt_ff == $past(bif.divisor))
		else $error("baud counter not reloaded by divisor write");
endmodule

// File: test/udi_far_model.sv
// Purpose: Outside receive and transmit path facing the register block
// Assumes: One clock; events arrive as one-cycle pulses from the bench
// Notes: ev_i bit 0 line error, bit 1 byte received, bit 2 holding register empty
`timescale 1ns/1ps
module udi_far_model (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic [2:0] ev_i,
	input wire logic rx_rd_i,
	input wire logic rx_clear_i,
	input wire logic tx_wr_i,
	output logic line_err_o,
	output logic rx_ready_o,
	output logic tx_empty_o,
	output logic [7:0] rx_byte_o,
	output logic [7:0] line_status_o
);
	// ----------------------------------------
	// Flags
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			line_err_o <= 1'b0;
			rx_ready_o <= 1'b0;
			tx_empty_o <= 1'b0;
		end else begin
			line_err_o <= ev_i[0];
			if (ev_i[1]) begin
				rx_ready_o <= 1'b1;
			end else if (rx_rd_i || rx_clear_i) begin
				rx_ready_o <= 1'b0;
			end
			if (ev_i[2]) begin
				tx_empty_o <= 1'b1;
			end else if (tx_wr_i) begin
				tx_empty_o <= 1'b0;
			end
		end
	end
	// Byte is only meaningful while data waits; otherwise it shows its inverse
	assign rx_byte_o = rx_ready_o ? 8'hA5 : 8'h5A;
	assign line_status_o = {2'h0, tx_empty_o, 4'h0, rx_ready_o};
endmodule

// File: test/udi_top_tb.sv
// Purpose: Self-checking bench for divisor latches and interrupt identification
// Assumes: Register port answers one cycle after each strobe
// Notes: Waits of four cycles cover the two-edge indication latency
`timescale 1ns/1ps
`include "udi_defs.svh"
module udi_top_tb;
	logic mclk_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, tmo = 1'b0, ce = 1'b1;
	logic [11:0] addr_i = 12'h000;
	logic [7:0] wdata_i = 8'h00, rdata_o, tx_byte_o, rx_byte, line_status_reg, lcr;
	logic [2:0] ev = 3'h0;
	logic [1:0] rx_trigger_o;
	logic tx_wr_o, rx_rd_o, div_sel, fen, rxclr, txclr, baud_tick_o, irq_o, err, rdy, txe;
	int fails = 0, num_checks = 0, n;

	always #4 mclk_i = ~mclk_i;

	udi_top dut (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_byte_i(rx_byte),
		.line_status_i(line_status_reg), .line_err_i(err), .rx_ready_i(rdy), .rx_timeout_i(tmo),
		.tx_holding_empty_flag_i(txe), .tx_byte_o(tx_byte_o), .tx_wr_o(tx_wr_o),
		.rx_rd_o(rx_rd_o), .line_ctrl_o(lcr), .divisor_access_select_o(div_sel),
		.fifo_enable_bit_o(fen), .receive_fifo_clear_o(rxclr), .transmit_fifo_clear_o(txclr),
		.rx_trigger_o(rx_trigger_o), .baud_tick_o(baud_tick_o), .irq_o(irq_o));
	udi_far_model far (.mclk_i(mclk_i), .reset_i(reset_i), .ev_i(ev), .rx_rd_i(rx_rd_o),
		.rx_clear_i(rxclr), .tx_wr_i(tx_wr_o), .line_err_o(err), .rx_ready_o(rdy),
		.tx_empty_o(txe), .rx_byte_o(rx_byte), .line_status_o(line_status_reg));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task end_sim;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task chk8(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
		end
	endtask
	task chk1(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask
	task settle;
		repeat (4) @(posedge mclk_i);
		#1;
	endtask
	task wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		#1;
	endtask
	task rd(input logic [11:0] a, input logic [7:0] exp);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		chk8(rdata_o, exp);
	endtask
	task ev_pulse(input int k);
		@(posedge mclk_i);
		ev[k] <= 1'b1;
		@(posedge mclk_i);
		ev[k] <= 1'b0;
		settle();
	endtask
	task wait_tick(output int cnt, input int lim);
		cnt = 0;
		@(posedge mclk_i);
		#1;
		while (baud_tick_o !== 1'b1 && cnt < lim) begin
			cnt++;
			@(posedge mclk_i);
			#1;
		end
		if (cnt >= lim) begin
			fails++;
			$display("wrong value at %0t: no baud tick", $time);
			end_sim();
		end
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge mclk_i);
		reset_i <= 1'b0;
		rd(`UDI_OFS_IDENT, 8'h01);
		chk1(irq_o, 1'b0);
		rd(12'h100, 8'h00);
		wr(`UDI_OFS_LCR, 8'h80);
		chk1(div_sel, 1'b1);
		chk8(lcr, 8'h80);
		wr(`UDI_OFS_DATA, 8'h00);
		chk1(tx_wr_o, 1'b0);
		for (int i = 2; i < 6; i += 3) begin
			wr(`UDI_OFS_DIVLO, 8'(i));
			wait_tick(n, 40);
			wait_tick(n, 40);
			chk8(8'(n), 8'(i));
		end
		wr(`UDI_OFS_DATA, 8'h01);
		wait_tick(n, 300);
		wait_tick(n, 300);
		chk8(8'(n - 256), 8'h05);
		wr(`UDI_OFS_DATA, 8'h00);
		wait_tick(n, 12);
		rd(`UDI_OFS_DATA, 8'h00);
		rd(`UDI_OFS_DIVLO, 8'h05);
		wr(`UDI_OFS_LCR, 8'h00);
		wr(`UDI_OFS_DIVLO, 8'h07);
		rd(`UDI_OFS_DIVLO, 8'h07);
		ev_pulse(2);
		rd(`UDI_OFS_IDENT, 8'h02);
		settle();
		rd(`UDI_OFS_IDENT, 8'h01);
		wr(`UDI_OFS_DATA, 8'h3C);
		ev_pulse(2);
		chk1(irq_o, 1'b1);
		ev_pulse(1);
		chk1(irq_o, 1'b1);
		rd(`UDI_OFS_IDENT, 8'h04);
		ev_pulse(0);
		rd(`UDI_OFS_IDENT, 8'h06);
		settle();
		rd(`UDI_OFS_LSTAT, 8'h21);
		settle();
		rd(`UDI_OFS_IDENT, 8'h04);
		settle();
		rd(`UDI_OFS_DATA, 8'hA5);
		chk1(rx_rd_o, 1'b1);
		settle();
		rd(`UDI_OFS_IDENT, 8'h02);
		settle();
		rd(`UDI_OFS_IDENT, 8'h01);
		wr(`UDI_OFS_DATA, 8'h5A);
		chk1(tx_wr_o, 1'b1);
		chk8(tx_byte_o, 8'h5A);
		ev_pulse(2);
		chk1(irq_o, 1'b1);
		wr(`UDI_OFS_DATA, 8'hC3);
		settle();
		rd(`UDI_OFS_IDENT, 8'h01);
		wr(`UDI_OFS_IDENT, 8'hC7);
		chk1(rxclr, 1'b1);
		chk1(txclr, 1'b1);
		@(posedge mclk_i);
		#1;
		chk1(rxclr, 1'b0);
		chk1(txclr, 1'b0);
		chk1(fen, 1'b1);
		chk8({6'h00, rx_trigger_o}, 8'h03);
		settle();
		rd(`UDI_OFS_IDENT, 8'hC1);
		@(posedge mclk_i);
		tmo <= 1'b1;
		settle();
		rd(`UDI_OFS_IDENT, 8'hCC);
		@(posedge mclk_i);
		tmo <= 1'b0;
		wr(`UDI_OFS_DIVLO, 8'h00);
		ev_pulse(0);
		chk1(irq_o, 1'b0);
		rd(`UDI_OFS_IDENT, 8'hC1);
		wr(`UDI_OFS_DIVLO, 8'h04);
		settle();
		rd(`UDI_OFS_IDENT, 8'hC6);
		@(posedge mclk_i);
		#1;
		chk8(rdata_o, 8'h00);
		wr(`UDI_OFS_IDENT, 8'h00);
		chk1(fen, 1'b0);
		chk1(rxclr, 1'b1);
		chk1(txclr, 1'b1);
		@(posedge mclk_i);
		ce <= 1'b0;
		wr(`UDI_OFS_DIVLO, 8'h01);
		@(posedge mclk_i);
		ce <= 1'b1;
		rd(`UDI_OFS_DIVLO, 8'h04);
		end_sim();
	end
endmodule
